// [inc/iesbu_pkg.sv]
// package for the upper interrupt enable bank: register map, bit masks,
// reset values and the bus-slave state type.
// assumes a 32-bit apb slave with byte addresses in a 12-bit window.
package iesbu_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W       = 12;
    localparam logic [11:0] OFS_SET_VIEW = 12'h000;    // write-one-to-set view
    localparam logic [11:0] OFS_CLR_VIEW = 12'h004;    // write-one-to-clear view

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    // bits 31:28 -> sources 63:60, 25:4 -> 57:36, 2 -> 34
    localparam logic [31:0] IMPL_MASK    = 32'hF3FF_FFF4;
    localparam logic [31:0] ENABLE_RST   = 32'h0000_0000;
    localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
    localparam int unsigned SRC_BASE     = 32;         // source of bit 0

    // ----------------------------------------------------------------
    // bus-slave state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_RESP = 2'h2
    } iesbu_state_e;

    typedef struct packed {
        iesbu_state_e state;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } iesbu_slave_s;

    localparam iesbu_slave_s SLAVE_RST = '{state: ST_IDLE, pready: 1'b0,
                                           pslverr: 1'b0, prdata: RDATA_RST};

    // state of the enable bank
    typedef struct packed {
        logic [31:0] enable;
    } iesbu_bank_s;

endpackage

// [inc/iesbu_if.sv]
// carrier between the bus slave and the enable bank.
// assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface iesbu_if;
    logic [31:0] set_bits;       // one pulse-wide mask of bits to enable
    logic [31:0] clear_bits;     // one pulse-wide mask of bits to disable
    logic [31:0] enable_state;   // present enable state, registered

    modport ctrl (output set_bits, output clear_bits, input enable_state);
    modport bank (input set_bits, input clear_bits, output enable_state);
endinterface

// [hw/iesbu_bank.sv]
// enable state of interrupt sources 34, 36 to 57 and 60 to 63, one flop per bit.
// assumes set and clear masks are single-cycle and already masked.
`timescale 1ns/1ps
module iesbu_bank
    import iesbu_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    iesbu_if.bank     bus
);

    iesbu_bank_s cur;
    iesbu_bank_s nxt;
    logic [31:0] next_enable;

    // ----------------------------------------------------------------
    // per-bit update
    // ----------------------------------------------------------------
    // set wins over clear so an enable is never lost to a racing clear
    for (genvar i = 0; i < 32; i++) begin : g_bit
        if (IMPL_MASK[i]) begin : g_impl
            assign next_enable[i] = bus.set_bits[i] ? 1'b1 :
                                    bus.clear_bits[i] ? 1'b0 :
                                    cur.enable[i];
        end else begin : g_resv
            assign next_enable[i] = 1'b0;
        end
    end

    // next state
    always_comb begin
        nxt        = cur;
        nxt.enable = next_enable;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur.enable <= ENABLE_RST;
        end else begin
            cur <= nxt;
        end
    end

    assign bus.enable_state = cur.enable;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    reserved_stay_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cur.enable & ~IMPL_MASK) == 32'h0000_0000)
        else $error("reserved enable bit set");

    reset_all_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (cur.enable == ENABLE_RST))
        else $error("enable not clear after reset");

endmodule

// [hw/iesbu_top.sv]
// apb slave for the upper interrupt enable bank: a set view and a clear
// view over one shared enable state, exported as a level vector.
// assumes a well-behaved apb master on pclk; paddr is a byte address.
`timescale 1ns/1ps
module iesbu_top
    import iesbu_pkg::*;
(
    input  wire  logic              pclk,
    input  wire  logic              presetn,
    input  wire  logic              psel,
    input  wire  logic              penable,
    input  wire  logic              pwrite,
    input  wire  logic [ADDR_W-1:0] paddr,
    input  wire  logic [31:0]       pwdata,
    output logic       [31:0]       prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic       [31:0]       irq_enable_bits
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    iesbu_if      u_if ();
    iesbu_slave_s cur;
    iesbu_slave_s nxt;
    logic         hit_set;
    logic         hit_clr;
    logic         addr_hit;
    logic         setup_phase;
    logic         access_edge;
    logic [31:0]  wdata_impl;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // full-width compare, so aliases inside the window are unmapped
    assign hit_set  = (paddr == OFS_SET_VIEW);
    assign hit_clr  = (paddr == OFS_CLR_VIEW);
    assign addr_hit = hit_set | hit_clr;

    // apb phases
    assign setup_phase = psel & ~penable;
    assign access_edge = psel & penable & cur.pready;

    // only implemented positions ever reach the bank
    assign wdata_impl = pwdata & IMPL_MASK;

    // ----------------------------------------------------------------
    // write strobes into the bank
    // ----------------------------------------------------------------
    // strobes fire only at the completing edge, so a held request
    // never writes twice; zero data bits leave their flops alone
    assign u_if.set_bits   = (access_edge & pwrite & hit_set) ?
                             wdata_impl : 32'h0000_0000;
    assign u_if.clear_bits = (access_edge & pwrite & hit_clr) ?
                             wdata_impl : 32'h0000_0000;

    // ----------------------------------------------------------------
    // enable bank
    // ----------------------------------------------------------------
    iesbu_bank u_bank (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (u_if.bank)
    );

    // ----------------------------------------------------------------
    // bus-slave next state
    // ----------------------------------------------------------------
    // answer is prepared in the setup cycle so pready stands in the
    // first access cycle: no wait states, at the cost of a registered
    // read path from the bank into prdata
    always_comb begin
        nxt = cur;
        case (cur.state)
            ST_IDLE: begin
                nxt.pready  = 1'b0;
                nxt.pslverr = 1'b0;
                if (setup_phase) begin
                    nxt.state   = ST_RESP;
                    nxt.pready  = 1'b1;
                    nxt.pslverr = ~addr_hit;
                    // both views read the same shared state
                    nxt.prdata  = (!pwrite && addr_hit) ?
                                  u_if.enable_state : RDATA_RST;
                end
            end
            ST_RESP: begin
                // access completes this cycle; drop pready and pslverr, prdata holds
                nxt.state   = ST_IDLE;
                nxt.pready  = 1'b0;
                nxt.pslverr = 1'b0;
            end
            default: begin
                nxt = SLAVE_RST;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // bus-slave state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= SLAVE_RST;
        end else begin
            cur <= nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs, each straight from a flop
    // ----------------------------------------------------------------
    assign prdata          = cur.prdata;
    assign pready          = cur.pready;
    assign pslverr         = cur.pslverr;
    assign irq_enable_bits = u_if.enable_state;   // bank flops

    // ----------------------------------------------------------------
    // checks on the register views
    // ----------------------------------------------------------------
    // reserved positions never show up on a read
    reserved_read_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |-> ((prdata & ~IMPL_MASK) == 32'h0000_0000))
        else $error("reserved bit read as one");

    // a one written to the set view is enabled one edge later
    set_view_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && hit_set)
        |=> ((irq_enable_bits & $past(wdata_impl)) == $past(wdata_impl)))
        else $error("set view write did not enable");

    // zero bits of a set or clear write keep their old value
    zero_keeps_state_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite)
        |=> ((irq_enable_bits & ~$past(pwdata)) ==
             ($past(irq_enable_bits) & ~$past(pwdata))))
        else $error("zero write changed enable state");

    // a mapped read returns the state seen at the setup cycle
    read_shows_state_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && addr_hit)
        |=> (pready && !pslverr && prdata == $past(irq_enable_bits)))
        else $error("read data differs from enable state");

    // a one written to the clear view is disabled one edge later
    clear_view_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && hit_clr)
        |=> ((irq_enable_bits & $past(wdata_impl)) == 32'h0000_0000))
        else $error("clear view write did not disable");

    // nothing is enabled until software asks for it
    reset_reads_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (irq_enable_bits == ENABLE_RST && !pready))
        else $error("state not zero after reset");

    // the answer stands for exactly one cycle
    ready_single_cycle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held over two cycles");

    // every setup cycle is answered on the next edge
    setup_answered_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> (pready && pslverr == $past(!addr_hit)))
        else $error("setup not answered in one cycle");

    // an unmapped write leaves the enable state alone
    unmapped_write_ignored_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && !addr_hit)
        |=> $stable(irq_enable_bits))
        else $error("unmapped write changed state");

    // ----------------------------------------------------------------
    // checks on the slave state and its answer
    // ----------------------------------------------------------------
    // one-hot codes, so a flipped state bit shows up here
    state_one_hot_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $onehot(cur.state))
        else $error("slave state not one-hot");

    // pready is the response state as seen from outside
    ready_tracks_state_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready == (cur.state == ST_RESP))
        else $error("pready out of step with state");

    // the response state lasts exactly one cycle
    resp_then_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cur.state == ST_RESP) |=> (cur.state == ST_IDLE))
        else $error("response state held too long");

    // an answer always follows a setup cycle
    ready_after_setup_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |-> $past(setup_phase))
        else $error("answer without a setup");

    // an error is only flagged together with the answer
    error_with_ready_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr without pready");

    // mapped places never answer with an error
    mapped_no_error_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && addr_hit) |=> !pslverr)
        else $error("mapped access refused");

    // refused reads return zero, so no state leaks out
    refused_read_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> (prdata == RDATA_RST))
        else $error("refused access returned data");

    // a write setup clears the read register
    write_clears_rdata_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && pwrite) |=> (prdata == RDATA_RST))
        else $error("read data left over after write");

    // prdata holds outside setups, so a slow master still sees it
    rdata_holds_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !setup_phase |=> $stable(prdata))
        else $error("read data changed without setup");

    // ----------------------------------------------------------------
    // checks on the strobes and the enable state
    // ----------------------------------------------------------------
    // set and clear never target the same bus cycle
    strobes_exclusive_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (u_if.set_bits & u_if.clear_bits) == 32'h0000_0000)
        else $error("set and clear strobes overlap");

    // reserved positions never reach the bank
    strobe_reserved_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((u_if.set_bits | u_if.clear_bits) & ~IMPL_MASK) == 32'h0000_0000)
        else $error("strobe on reserved bit");

    // a set strobe only at the completing edge of a set-view write
    set_strobe_gated_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (u_if.set_bits != 32'h0000_0000) |-> (access_edge && pwrite && hit_set))
        else $error("set strobe outside a set write");

    // likewise for the clear strobe
    clear_strobe_gated_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (u_if.clear_bits != 32'h0000_0000) |-> (access_edge && pwrite && hit_clr))
        else $error("clear strobe outside a clear write");

    // a set-view write never disables anything
    set_keeps_enabled_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_edge && pwrite && hit_set)
        |=> ((irq_enable_bits & $past(irq_enable_bits)) == $past(irq_enable_bits)))
        else $error("set write disabled a source");

    // a clear-view write never enables anything
    clear_never_sets_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_edge && pwrite && hit_clr)
        |=> ((irq_enable_bits & ~$past(irq_enable_bits)) == 32'h0000_0000))
        else $error("clear write enabled a source");

    // without a completing write the state stays put
    idle_keeps_state_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access_edge && pwrite) |=> $stable(irq_enable_bits))
        else $error("state changed without a write");

    // reads of either view leave the state alone
    read_keeps_state_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_edge && !pwrite) |=> $stable(irq_enable_bits))
        else $error("read changed enable state");

    // reserved positions of the exported vector stay low
    vector_reserved_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (irq_enable_bits & ~IMPL_MASK) == 32'h0000_0000)
        else $error("reserved vector bit set");

    // the strobes are quiet while no transfer is under way
    strobes_quiet_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !psel |-> ((u_if.set_bits | u_if.clear_bits) == 32'h0000_0000))
        else $error("strobe while bus idle");

    // a refused write leaves no strobe behind
    refused_no_strobe_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_edge && !addr_hit) |-> ((u_if.set_bits | u_if.clear_bits) == 32'h0000_0000))
        else $error("strobe on refused write");

    // a read never raises a strobe
    read_no_strobe_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_edge && !pwrite) |-> ((u_if.set_bits | u_if.clear_bits) == 32'h0000_0000))
        else $error("strobe on read");

endmodule

// [testbench/tb_irq_enable_set_bank_upper.sv]
// self-checking bench for the upper interrupt enable bank: apb read and
// write tasks, then sequences of calls against an expected enable word.
// assumes iesbu_top with zero-wait apb and unmapped accesses answered
// with pslverr.
`timescale 1ns/1ps
module tb_irq_enable_set_bank_upper
    import iesbu_pkg::*;
();

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [31:0]       irq_enable_bits;
    logic [31:0]       exp_en;
    int                num_errors;
    int                samples_checked;
    int                bit_list [8] = '{31, 28, 27, 25, 4, 3, 2, 0};

    iesbu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                   .pready(pready), .pslverr(pslverr), .irq_enable_bits(irq_enable_bits));

    // 5 ns period, inputs all defined at time zero
    always #2.5 pclk = ~pclk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; waits an edge first so psel is never assigned twice
    // in one time step between transfers
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("MISMATCH t=%0t pready never came", $time);
            tally_and_finish();
        end
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] addr, input logic [31:0] data, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, addr, data, rd, err);
        chk({31'h0, err}, {31'h0, exp_err}, "write pslverr");
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] addr, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        xfer(1'b0, addr, 32'h0000_0000, rd, err);
        chk(rd, exp, "read data");
        chk({31'h0, err}, {31'h0, exp_err}, "read pslverr");
    endtask

    // both views and the exported vector must agree with the expected word
    task automatic check_state();
        rd_reg(OFS_SET_VIEW, exp_en, 1'b0);
        rd_reg(OFS_CLR_VIEW, exp_en, 1'b0);
        chk(irq_enable_bits, exp_en, "enable vector");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        num_errors = 0;
        samples_checked = 0;
        exp_en = 32'h0000_0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check_state();
        $display("test reset done");

        wr_reg(OFS_SET_VIEW, 32'h0000_0004, 1'b0);
        exp_en = 32'h0000_0004;
        check_state();
        wr_reg(OFS_SET_VIEW, 32'h0000_0000, 1'b0);
        check_state();
        wr_reg(OFS_SET_VIEW, 32'hFFFF_FFFF, 1'b0);
        exp_en = 32'hF3FF_FFF4;
        check_state();
        $display("test set view done");

        wr_reg(OFS_CLR_VIEW, 32'h1000_0014, 1'b0);
        exp_en = 32'hE3FF_FFE0;
        check_state();
        wr_reg(OFS_CLR_VIEW, 32'h0000_0000, 1'b0);
        check_state();
        $display("test clear view done");

        // boundary bits, reserved neighbours included: each alone
        foreach (bit_list[i]) begin
            wr_reg(OFS_CLR_VIEW, 32'hFFFF_FFFF, 1'b0);
            wr_reg(OFS_SET_VIEW, 32'h0000_0001 << bit_list[i], 1'b0);
            exp_en = (32'h0000_0001 << bit_list[i]) & 32'hF3FF_FFF4;
            check_state();
        end
        $display("test single bits done");

        // unmapped places are refused and leave the state alone
        wr_reg(12'h008, 32'hFFFF_FFFF, 1'b1);
        rd_reg(12'h008, 32'h0000_0000, 1'b1);
        wr_reg(12'hFFC, 32'h0000_0000, 1'b1);
        check_state();
        $display("test unmapped done");

        // second reset in mid-run with sources enabled
        wr_reg(OFS_SET_VIEW, 32'hFFFF_FFFF, 1'b0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(irq_enable_bits, 32'h0000_0000, "vector in reset");
        presetn <= 1'b1;
        exp_en = 32'h0000_0000;
        check_state();
        $display("test second reset done");
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // run-length guard
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("MISMATCH t=%0t run too long", $time);
        tally_and_finish();
    end
endmodule
